/* File: design/alert_limits_map.vh */
// Register sub-addresses, field positions and timing for the alert logic.
// Assumes a 25 MHz system clock; included by the warm-up timer and alert logic files.
`ifndef ALERT_LIMITS_MAP_VH
`define ALERT_LIMITS_MAP_VH

// =============================================================
// Sub-addresses
`define ADDR_VBAT_LO      8'h01
`define ADDR_VBAT_HI      8'h02
`define ADDR_VIN_LO       8'h03
`define ADDR_VIN_HI       8'h04
`define ADDR_VSYS_LO      8'h05
`define ADDR_VSYS_HI      8'h06
`define ADDR_IIN_HI       8'h07
`define ADDR_IBAT_LO      8'h08
`define ADDR_DIE_HI       8'h09
`define ADDR_BSR_HI       8'h0a
`define ADDR_NTC_HI       8'h0b
`define ADDR_NTC_LO       8'h0c
`define ADDR_LIM_EN       8'h0d
`define ADDR_PHASE_EN     8'h0e
`define ADDR_QCNT_LO      8'h10
`define ADDR_QCNT_HI      8'h11
`define ADDR_LIM_FLAGS    8'h36
`define ADDR_PHASE_FLAGS  8'h37
`define ADDR_MEAS_VALID   8'h4a

// =============================================================
// Reset values
`define LIMIT_RESET       16'h0000
`define ENABLE_RESET      16'h0000

// =============================================================
// Limit flag bit positions
`define BIT_MEAS_VALID    15
`define BIT_QCNT_LO       13
`define BIT_QCNT_HI       12
`define BIT_VBAT_LO       11
`define BIT_VBAT_HI       10
`define BIT_VIN_LO        9
`define BIT_VIN_HI        8
`define BIT_VSYS_LO       7
`define BIT_VSYS_HI       6
`define BIT_IIN_HI        5
`define BIT_IBAT_LO       4
`define BIT_DIE_HI        3
`define BIT_BSR_HI        2
`define BIT_NTC_HI        1
`define BIT_NTC_LO        0

// =============================================================
// Widths and timing
`define PHASE_WIDTH       11
`define WARMUP_US         12000
`define CLK_MHZ           25
`define WARMUP_CYCLES     (`WARMUP_US * `CLK_MHZ)
`define WARMUP_CNT_W      19

`endif

/* File: design/limit_compare.v */
// One signed limit comparison against a fresh measurement result.
// Assumes operands and strobe come from logic on the same clock.
`timescale 1ns/1ps
module limit_compare (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Operands
  input  wire [15:0] value,
  input  wire [15:0] limit,
  input  wire        is_high,
  input  wire        enable,
  input  wire        sample,
  // Result
  output reg         trip
);

  // ===========================================================
  // Compare only on a new result, so a stale value cannot trip
  always @(posedge clk) begin
    if (rst) begin
      trip <= 1'b0;
    end else begin
      trip <= sample & enable &
              (is_high ? ($signed(value) > $signed(limit))
                       : ($signed(value) < $signed(limit)));
    end
  end

endmodule // limit_compare

/* File: design/warmup_timer.v */
// Measurement warm-up timer: counts up through the settle time after reset.
// Assumes one free-running clock at the rate set in the map header.
`timescale 1ns/1ps
`include "alert_limits_map.vh"
module warmup_timer #(
  parameter WARMUP_CYCLES = `WARMUP_CYCLES
) (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Status
  output reg  done
);

  reg [`WARMUP_CNT_W-1:0] count_r;

  // ===========================================================
  // Saturating counter; done stays high once reached
  always @(posedge clk) begin
    if (rst) begin
      count_r <= {`WARMUP_CNT_W{1'b0}};
      done    <= 1'b0;
    end else if (!done) begin
      count_r <= count_r + 1'b1;
      done    <= (count_r == WARMUP_CYCLES[`WARMUP_CNT_W-1:0] - 1'b1);
    end
  end

endmodule // warmup_timer

/* File: design/limit_alert_logic.v */
// Telemetry limit alert logic: limit registers, enables, sticky flags
// and the open-drain alert line. Assumes a host drives the register
// port from logic on clk; measurement results arrive with a strobe.
// =============================================================
// Overview of operation
// - Input current high limit at 0x07; flag when input current exceeds it.
// - Battery current low limit at 0x08, compared signed; discharge trips.
// - Die temperature high limit at 0x09, same format as the reading.
// - Series resistance high limit at 0x0a detects excessive resistance.
// - Thermistor ratio above high limit is cold, below low is hot.
// - Enable register 0x0d gates each limit monitor and its reporting.
// - Alert when measurement becomes valid after about 12 ms warm-up.
// - Charger stays idle until warm-up ends, whatever the enable.
// - Counter below low or above high limit sets its flag, alerts.
// - Battery voltage out of its limits sets its flag and alerts.
// - Input voltage out of its limits sets its flag and alerts.
// - System voltage out of its limits sets its flag and alerts.
// - Input current high and battery current low set flags, alert.
// - Die temperature and resistance above high limits set flags.
// - Thermistor cold and hot conditions set flags and alert.
// - Eleven-bit phase enable register at 0x0e gates phase alerts.
// - Alert during enabled equalize and absorb phases.
// - Alert while charger is suspended, when enabled.
// - Alert during enabled precondition phase.
// - Alert during enabled main charge phase.
// - Alert while charging paused by thermistor range, when enabled.
// - Alert on timer termination and current-fraction termination.
`timescale 1ns/1ps
`include "alert_limits_map.vh"
module limit_alert_logic #(
  parameter WARMUP_CYCLES = `WARMUP_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Register port from the serial interface
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  // Measurement results, one strobe per new set
  input  wire        meas_strobe,
  input  wire [15:0] battery_voltage,
  input  wire [15:0] input_voltage,
  input  wire [15:0] system_voltage,
  input  wire [15:0] battery_current,
  input  wire [15:0] input_current,
  input  wire [15:0] die_temperature,
  input  wire [15:0] thermistor_ratio,
  input  wire [15:0] series_resistance,
  input  wire [15:0] charge_counter,
  // Charger phase, from the charge state machine
  input  wire [10:0] charger_phase,
  // Alert line, open drain
  input  wire        alert_in,
  output reg         alert_out,
  output reg         alert_oe,
  // Charger run permission
  output reg         charger_run
);

  // ===========================================================
  // Limit storage, indexed by comparator
  localparam NCMP = 14;
  reg [15:0] lim_r [0:NCMP-1];
  reg [15:0] lim_en_r;
  reg [10:0] phase_en_r;
  reg [15:0] lim_flags_r;
  reg [15:0] lim_flags_nxt;
  reg [10:0] phase_flags_r;
  reg [10:0] phase_flags_nxt;
  reg        meas_valid_r;
  reg        alert_in_s1_r;
  reg        alert_in_s2_r;

  wire        warm_done;
  wire [NCMP-1:0] trip;
  wire [NCMP*16-1:0] values;
  wire [NCMP*4-1:0]  bitpos;
  wire [NCMP-1:0]    is_high;
  wire [7:0]  cmp_addr [0:NCMP-1];

  // ===========================================================
  // Comparator table: value, flag bit, direction, sub-address
  assign values = {charge_counter,   charge_counter,
                   battery_voltage,  battery_voltage,
                   input_voltage,    input_voltage,
                   system_voltage,   system_voltage,
                   input_current,    battery_current,
                   die_temperature,  series_resistance,
                   thermistor_ratio, thermistor_ratio};
  assign bitpos = {4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7,
                   4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  // Bits 13 to 6 alternate low and high; 4 and 0 are the only other low limits
  assign is_high = 14'b01_0101_0110_1110;
  assign cmp_addr[13] = `ADDR_QCNT_LO;
  assign cmp_addr[12] = `ADDR_QCNT_HI;
  assign cmp_addr[11] = `ADDR_VBAT_LO;
  assign cmp_addr[10] = `ADDR_VBAT_HI;
  assign cmp_addr[9]  = `ADDR_VIN_LO;
  assign cmp_addr[8]  = `ADDR_VIN_HI;
  assign cmp_addr[7]  = `ADDR_VSYS_LO;
  assign cmp_addr[6]  = `ADDR_VSYS_HI;
  assign cmp_addr[5]  = `ADDR_IIN_HI;
  assign cmp_addr[4]  = `ADDR_IBAT_LO;
  assign cmp_addr[3]  = `ADDR_DIE_HI;
  assign cmp_addr[2]  = `ADDR_BSR_HI;
  assign cmp_addr[1]  = `ADDR_NTC_HI;
  assign cmp_addr[0]  = `ADDR_NTC_LO;

  // ===========================================================
  // Measurement warm-up
  warmup_timer #(
    .WARMUP_CYCLES (WARMUP_CYCLES)
  ) u_warmup (
    .clk  (clk),
    .rst  (rst),
    .done (warm_done)
  );

  // ===========================================================
  // Per-limit storage and comparators
  genvar g;
  generate
    for (g = 0; g < NCMP; g = g + 1) begin : g_cmp
      // Limit register write
      always @(posedge clk) begin
        if (rst) begin
          lim_r[g] <= `LIMIT_RESET;
        end else if (reg_wr && reg_addr == cmp_addr[g]) begin
          lim_r[g] <= reg_wdata;
        end
      end
      // Signed compare on each new result, gated by enable
      limit_compare u_cmp (
        .clk     (clk),
        .rst     (rst),
        .value   (values[g*16 +: 16]),
        .limit   (lim_r[g]),
        .is_high (is_high[g]),
        .enable  (lim_en_r[bitpos[g*4 +: 4]]),
        .sample  (meas_strobe & meas_valid_r),
        .trip    (trip[g])
      );
    end
  endgenerate

  // ===========================================================
  // Enable registers
  always @(posedge clk) begin
    if (rst) begin
      lim_en_r   <= `ENABLE_RESET;
      phase_en_r <= {`PHASE_WIDTH{1'b0}};
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_LIM_EN) begin
        lim_en_r <= reg_wdata & 16'hbfff;
      end
      if (reg_addr == `ADDR_PHASE_EN) begin
        phase_en_r <= reg_wdata[10:0];
      end
    end
  end

  // ===========================================================
  // Limit flags: sticky, set wins over a write-zero clear
  integer i;
  always @* begin
    lim_flags_nxt = lim_flags_r;
    if (reg_wr && reg_addr == `ADDR_LIM_FLAGS) begin
      lim_flags_nxt = lim_flags_r & reg_wdata;
    end
    for (i = 0; i < NCMP; i = i + 1) begin
      if (trip[i]) begin
        lim_flags_nxt[bitpos[i*4 +: 4]] = 1'b1;
      end
    end
    // Valid event fires once on the warm-up edge
    if (warm_done && !meas_valid_r && lim_en_r[`BIT_MEAS_VALID]) begin
      lim_flags_nxt[`BIT_MEAS_VALID] = 1'b1;
    end
    lim_flags_nxt[14] = 1'b0;
  end

  // ===========================================================
  // Phase flags: set while in an enabled phase
  always @* begin
    phase_flags_nxt = phase_flags_r;
    if (reg_wr && reg_addr == `ADDR_PHASE_FLAGS) begin
      phase_flags_nxt = phase_flags_r & reg_wdata[10:0];
    end
    phase_flags_nxt = phase_flags_nxt | (charger_phase & phase_en_r);
  end

  always @(posedge clk) begin
    if (rst) begin
      lim_flags_r   <= 16'h0000;
      phase_flags_r <= {`PHASE_WIDTH{1'b0}};
      meas_valid_r  <= 1'b0;
    end else begin
      lim_flags_r   <= lim_flags_nxt;
      phase_flags_r <= phase_flags_nxt;
      meas_valid_r  <= warm_done;
    end
  end

  // ===========================================================
  // Alert line pulled low while any flag is set
  always @(posedge clk) begin
    if (rst) begin
      alert_out     <= 1'b0;
      alert_oe      <= 1'b0;
      alert_in_s1_r <= 1'b1;
      alert_in_s2_r <= 1'b1;
    end else begin
      alert_out     <= 1'b0;
      alert_oe      <= (|lim_flags_nxt) | (|phase_flags_nxt);
      alert_in_s1_r <= alert_in;
      alert_in_s2_r <= alert_in_s1_r;
    end
  end

  // ===========================================================
  // Charger held idle until warm-up completes
  always @(posedge clk) begin
    if (rst) begin
      charger_run <= 1'b0;
    end else begin
      charger_run <= warm_done;
    end
  end

  // ===========================================================
  // Register readback, one cycle after the read strobe
  reg [15:0] rd_mux;
  integer k;
  always @* begin
    rd_mux = 16'h0000;
    for (k = 0; k < NCMP; k = k + 1) begin
      if (reg_addr == cmp_addr[k]) begin
        rd_mux = lim_r[k];
      end
    end
    case (reg_addr)
      `ADDR_LIM_EN:      rd_mux = lim_en_r;
      `ADDR_PHASE_EN:    rd_mux = {5'h00, phase_en_r};
      `ADDR_LIM_FLAGS:   rd_mux = lim_flags_r;
      `ADDR_PHASE_FLAGS: rd_mux = {5'h00, phase_flags_r};
      `ADDR_MEAS_VALID:  rd_mux = {15'h0000, meas_valid_r};
      8'hff:             rd_mux = {15'h0000, alert_in_s2_r};
      default:           rd_mux = rd_mux;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

endmodule // limit_alert_logic

/* File: testbench/limit_alert_props.sv */
// Checker for the limit alert logic, watching top ports only.
// Assumes it is bound to limit_alert_logic by the bench.
`timescale 1ns/1ps
module limit_alert_props #(
  parameter WARMUP_CYCLES = 300000
) (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Register port
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_rvalid,
  // Measurements and phase
  input wire        meas_strobe,
  input wire [15:0] input_current,
  input wire [10:0] charger_phase,
  // Alert and run
  input wire        alert_out,
  input wire        alert_oe,
  input wire        charger_run
);
  // ===========================================================
  // Mirrors of written registers and a cycle count since reset
  reg [15:0] en_r;
  reg [15:0] lim_r;
  reg [10:0] ph_r;
  reg [19:0] cnt_r;
  always @(posedge clk) begin
    if (rst) begin
      en_r  <= 16'h0000;
      lim_r <= 16'h0000;
      ph_r  <= 11'h000;
      cnt_r <= 20'h00000;
    end else begin
      if (reg_wr && reg_addr == 8'h0d) en_r <= reg_wdata;
      if (reg_wr && reg_addr == 8'h07) lim_r <= reg_wdata;
      if (reg_wr && reg_addr == 8'h0e) ph_r <= reg_wdata[10:0];
      // Saturate so a long run never wraps into warm-up again
      if (cnt_r != 20'hfffff) cnt_r <= cnt_r + 20'h00001;
    end
  end

  // ===========================================================
  // Properties
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_read;
    reg_rd ##1 reg_rvalid;
  endsequence
  sequence s_trip;
    meas_strobe && charger_run && en_r[5]
      && ($signed(input_current) > $signed(lim_r));
  endsequence
  a_read_answer: assert property (reg_rd |-> s_read)
    else $error("read strobe got no answer");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  a_alert_sticky: assert property (alert_oe && !(reg_wr &&
      (reg_addr == 8'h36 || reg_addr == 8'h37)) |=> alert_oe)
    else $error("alert dropped without clear");
  a_line_low: assert property (alert_out == 1'b0)
    else $error("alert line driven high");
  a_run_held: assert property (charger_run |=> charger_run)
    else $error("run permission dropped");
  a_warmup_idle: assert property ((cnt_r + 2 < WARMUP_CYCLES)
      |-> !charger_run)
    else $error("charger ran during warm-up");
  a_warmup_end: assert property ((cnt_r > WARMUP_CYCLES + 2)
      |-> charger_run)
    else $error("charger idle after warm-up");
  a_valid_alert: assert property ($rose(charger_run) && en_r[15]
      |-> ##[0:2] alert_oe)
    else $error("no alert on measurement valid");
  a_input_trip: assert property (s_trip |-> ##2 alert_oe)
    else $error("input current over limit not flagged");
  a_phase_alert: assert property (charger_run
      && |(charger_phase & ph_r) |-> ##[1:2] alert_oe)
    else $error("enabled phase gave no alert");
endmodule // limit_alert_props

/* File: testbench/host_model.sv */
// Host model: drives the register port as the serial bridge would.
// Assumes the block's clock; requests change on falling edges.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire         clk,
  // Register port
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [7:0]  reg_addr,
  output reg  [15:0] reg_wdata,
  input  wire [15:0] reg_rdata,
  input  wire        reg_rvalid
);
  // Idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  // One write strobe; released fields show inverted stale values
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask
  // Read; unknown comes back if the answer pulse is missing
  task rd(input [7:0] a, output [15:0] d);
    begin
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    end
  endtask
endmodule // host_model

/* File: testbench/telemetry_limit_alert_logic_bench.sv */
// Self-checking bench for the limit alert logic with a host model.
// Assumes a short warm-up parameter so the run stays brief.
`timescale 1ns/1ps
module telemetry_limit_alert_logic_bench;
  localparam WARMUP = 200;
  reg         clk;
  reg         rst;
  reg         meas_strobe;
  reg  [15:0] meas;
  reg  [10:0] charger_phase;
  wire        reg_wr, reg_rd, reg_rvalid, alert_out, alert_oe;
  wire        charger_run;
  wire [7:0]  reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  wire        alert_in = ~alert_oe; // Pulled-up open-drain wire
  integer     num_errors, checks_done, b, i;
  reg  [31:0] seed_r;
  reg  [15:0] d, lim, v, en, want;

  limit_alert_logic #(.WARMUP_CYCLES(WARMUP)) limit_alert_logic_inst (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .meas_strobe(meas_strobe),
    .battery_voltage(meas), .input_voltage(meas), .system_voltage(meas),
    .battery_current(meas), .input_current(meas),
    .die_temperature(meas), .thermistor_ratio(meas),
    .series_resistance(meas), .charge_counter(meas),
    .charger_phase(charger_phase), .alert_in(alert_in),
    .alert_out(alert_out), .alert_oe(alert_oe), .charger_run(charger_run));
  host_model host_model_inst (.clk(clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ===========================================================
  // Helpers
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Limit address and direction of each limit flag bit
  function [7:0] lim_addr(input integer n);
    lim_addr = (n >= 12) ? 8'h1d - n[7:0] : 8'h0c - n[7:0];
  endfunction
  function is_hi(input integer n);
    is_hi = (n == 1 || n == 2 || n == 3 || n == 5 || (n >= 6 && n % 2 == 0));
  endfunction
  function trips(input integer n, input [15:0] x, input [15:0] l);
    trips = is_hi(n) ? ($signed(x) > $signed(l)) : ($signed(x) < $signed(l));
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (num_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 20000);
    num_errors = num_errors + 1;
    wrap_up;
  end

  // ===========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    meas_strobe = 1'b0;
    meas = 16'h0000;
    charger_phase = 11'h000;
    num_errors = 0;
    checks_done = 0;
    seed_r = 32'd60;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    // Reset values, unmapped place, read-only bit 14
    for (b = 1; b <= 17; b = b + 1) begin
      host_model_inst.rd(b[7:0], d);
      check(d, 16'h0000);
    end
    host_model_inst.wr(8'h20, 16'h1234);
    host_model_inst.rd(8'h20, d);
    check(d, 16'h0000);
    host_model_inst.wr(8'h0d, 16'hffff);
    host_model_inst.rd(8'h0d, d);
    check(d, 16'hbfff);
    host_model_inst.wr(8'h0e, 16'hffff);
    host_model_inst.rd(8'h0e, d);
    check(d, 16'h07ff);
    host_model_inst.wr(8'h0e, 16'h0000);
    host_model_inst.wr(8'h0d, 16'h8000);
    // Warm-up ends, valid alert, line sensed low, then cleared
    i = 0;
    while (!charger_run && i < 1000) begin
      @(negedge clk);
      i = i + 1;
    end
    check({15'h0, charger_run}, 16'h0001);
    host_model_inst.rd(8'h36, d);
    check(d, 16'h8000);
    host_model_inst.rd(8'hff, d);
    check({15'h0, d[0]}, 16'h0000);
    host_model_inst.wr(8'h36, 16'h0000);
    check({15'h0, alert_oe}, 16'h0000);
    // Every limit: equal, adjacent, random, then disabled
    for (b = 0; b < 14; b = b + 1) begin
      for (i = 0; i < 4; i = i + 1) begin
        seed_r = xs(seed_r);
        lim = seed_r[15:0];
        seed_r = xs(seed_r);
        v = (i == 0) ? lim : (i == 1) ? (is_hi(b) ? lim + 1 : lim - 1)
          : seed_r[15:0];
        en = (i == 3) ? 16'h0000 : (16'h0001 << b);
        want = (i != 3 && trips(b, v, lim)) ? (16'h0001 << b) : 16'h0000;
        host_model_inst.wr(lim_addr(b), lim);
        host_model_inst.wr(8'h0d, en);
        host_model_inst.wr(8'h36, 16'h0000);
        @(negedge clk);
        meas = v;
        meas_strobe = 1'b1;
        @(negedge clk);
        meas_strobe = 1'b0;
        repeat (2) @(negedge clk);
        host_model_inst.rd(8'h36, d);
        check(d, want);
        check({15'h0, alert_oe}, {15'h0, |want});
      end
    end
    // Each charger phase against a random enable set
    host_model_inst.wr(8'h0d, 16'h0000);
    host_model_inst.wr(8'h36, 16'h0000);
    for (b = 0; b < 11; b = b + 1) begin
      seed_r = xs(seed_r);
      en = {5'h00, seed_r[10:0] | (11'h001 << b)};
      seed_r = xs(seed_r);
      host_model_inst.wr(8'h0e, en);
      charger_phase = seed_r[10:0] | (11'h001 << b);
      repeat (3) @(negedge clk);
      want = en & {5'h00, charger_phase};
      charger_phase = 11'h000;
      host_model_inst.rd(8'h37, d);
      check(d, want);
      host_model_inst.wr(8'h37, 16'h0000);
      check({15'h0, alert_oe}, 16'h0000);
    end
    wrap_up;
  end
endmodule // telemetry_limit_alert_logic_bench

bind limit_alert_logic limit_alert_props #(
  .WARMUP_CYCLES(WARMUP_CYCLES)
) limit_alert_props_inst (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid),
  .meas_strobe(meas_strobe), .input_current(input_current),
  .charger_phase(charger_phase), .alert_out(alert_out),
  .alert_oe(alert_oe), .charger_run(charger_run));
